// ==== test/host_kicker.sv ====
/*
 * Host model that services the watchdog kick pin at a given period.
 * Assumes the bench keeps the period below the scaled timeout while run is high.
 */
module host_kicker (
	input wire logic clk,
	input wire logic run,
	input wire logic [31:0] period,
	output logic kick
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] cnt;
	initial begin
		kick = 1'b1;
		cnt = 32'h0;
	end
	// line idles high so every kick is a clean falling edge
	always @(posedge clk) begin
		if (!run) begin
			cnt <= 32'h0;
			kick <= 1'b1;
		end else begin
			cnt <= (cnt >= period) ? 32'h0 : cnt + 32'h1;
			kick <= (cnt >= 32'd60);
		end
	end
endmodule

// ==== test/testbench.sv ====
/*
 * Self-checking bench for the watchdog supervisor: bus, supervisor and watchdog runs.
 * Assumes the design's clamped minimum timeout and hold delay; short pin filters.
 */
`define CHK(nm, e, g) begin \
	check_count++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
	end \
end

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset, manual_reset_n, supply_low, kick, run_en, sel0, sel1;
	logic hsel, hwrite, hreadyout, hresp, reset_out_n, fault_n, rd_pend, run;
	logic [31:0] haddr, hwdata, hrdata, period, exp_rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] exp_q[$];
	int n_errors, check_count, seed, n;

	timeout_watchdog_supervisor #(.BASE_TIMEOUT_US(1000), .START_DELAY_US(0),
		.HOLD_DELAY_US(2000), .SET_HOLD_CYCLES(4), .ENABLE_HOLD_CYCLES(4))
	i_timeout_watchdog_supervisor (.clk(clk), .reset(reset), .manual_reset_n(manual_reset_n),
		.supply_low(supply_low), .watchdog_kick_in(kick), .watchdog_run_enable(run_en),
		.scale_select_0(sel0), .scale_select_1(sel1), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .reset_out_n(reset_out_n),
		.watchdog_fault_out_n(fault_n));
	host_kicker i_host_kicker (.clk(clk), .run(run), .period(period), .kick(kick));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic stop_test;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic edge_ready;
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (hreadyout !== 1'b1) begin
			n_errors++;
			$display("CHECK FAILED hready expected 1 seen timeout");
			stop_test();
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		edge_ready();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		edge_ready();
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask

	// waits for a pin level; sel 1 picks the fault output, 0 the reset output
	task automatic wait_pin(input bit sel, input logic lvl, input int max, output int k);
		k = 0;
		while ((sel ? fault_n : reset_out_n) !== lvl) begin
			@(posedge clk);
			k++;
			if (k > max) begin
				n_errors++;
				$display("CHECK FAILED pin wait expected %h seen timeout", lvl);
				stop_test();
			end
		end
	endtask

	// read data is judged at the edge that closes the data phase
	always @(posedge clk) begin
		if (rd_pend) begin
			exp_rd = exp_q.pop_front();
			`CHK("hrdata", exp_rd, hrdata)
		end
		rd_pend <= !reset && hsel && htrans[1] && !hwrite;
	end

	initial begin
		seed = 45;
		{n_errors, check_count} = '0;
		{reset, manual_reset_n, supply_low, run_en, sel0, sel1} = 6'b110000;
		{hsel, hwrite, htrans, rd_pend, run} = '0;
		{haddr, hwdata} = '0;
		hsize = 3'h2;
		period = 32'd30000;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rd(8'h00, 32'h2);
		rd(8'h10, 32'h0);
		rd(8'h08, 32'h0);
		bus(1'b1, 8'h00, 32'h3);
		rd(8'h00, 32'h3);
		bus(1'b1, 8'h00, 32'h2);
		`CHK("reset_out_n", 1'b0, reset_out_n)
		$display("test bus done");
		manual_reset_n <= 1'b0;
		supply_low <= 1'b1;
		repeat (10) @(posedge clk);
		`CHK("reset_out_n", 1'b0, reset_out_n)
		manual_reset_n <= 1'b1;
		repeat (5) @(posedge clk);
		supply_low <= 1'b0;
		wait_pin(0, 1'b1, 300000, n);
		`CHK("hold delay", 1'b1, n >= 199900)
		$display("test supervisor done");
		run_en <= 1'b1;
		period <= 32'd20000 + ($unsigned($random(seed)) % 30000);
		run <= 1'b1;
		repeat (60000) @(posedge clk);
		sel0 <= 1'b1;
		repeat (60000) @(posedge clk);
		sel0 <= 1'b0;
		`CHK("fault_n", 1'b1, fault_n)
		run <= 1'b0;
		wait_pin(1, 1'b0, 120000, n);
		`CHK("reset_out_n", 1'b1, reset_out_n)
		wait_pin(1, 1'b1, 250000, n);
		`CHK("fault pulse", 1'b1, n >= 199800)
		$display("test watchdog done");
		bus(1'b1, 8'h00, 32'h3);
		wait_pin(1, 1'b0, 120000, n);
		repeat (1000) @(posedge clk);
		`CHK("fault_n", 1'b0, fault_n)
		bus(1'b1, 8'h08, 32'h1);
		wait_pin(1, 1'b1, 10, n);
		bus(1'b1, 8'h00, 32'h0);
		wait_pin(0, 1'b0, 120000, n);
		`CHK("fault_n", 1'b1, fault_n)
		run_en <= 1'b0;
		repeat (50) @(posedge clk);
		`CHK("fault_n", 1'b1, fault_n)
		rd(8'h00, 32'h0);
		$display("test latched and shared done");
		stop_test();
	end
endmodule

// ==== test/wd_asserts.sv ====
/*
 * Concurrent checks on the watchdog supervisor top ports.
 * Assumes one clock, synchronous active-high reset; bound to every instance below.
 */
module wd_asserts #(
	parameter int BASE_US = 1000,
	parameter int HOLD_US = 2000
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic manual_reset_n,
	input wire logic supply_low,
	input wire logic watchdog_kick_in,
	input wire logic watchdog_run_enable,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic reset_out_n,
	input wire logic watchdog_fault_out_n
);
	logic [31:0] rel_cnt;
	logic [31:0] low_cnt;
	logic [31:0] kick_age;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// counters measure from the pins, so they never undercount the design's synced view
	always_ff @(posedge clk) begin
		if (reset || reset_out_n || !manual_reset_n || supply_low)
			rel_cnt <= 32'h0;
		else
			rel_cnt <= rel_cnt + 32'h1;
		low_cnt <= (reset || watchdog_fault_out_n) ? 32'h0 : low_cnt + 32'h1;
		if (reset || $fell(watchdog_kick_in))
			kick_age <= 32'h0;
		else if (!kick_age[31])
			kick_age <= kick_age + 32'h1;
	end
	a_manual_forces_reset: assert property (!manual_reset_n [*4] |-> !reset_out_n)
		else $error("reset output high while manual reset held low");
	a_supply_forces_reset: assert property (supply_low [*4] |-> !reset_out_n)
		else $error("reset output high while supply low");
	a_fault_needs_run: assert property (!watchdog_fault_out_n |-> reset_out_n)
		else $error("fault output low while reset asserted");
	a_reset_clears_fault: assert property ($fell(reset_out_n) |=> watchdog_fault_out_n [*2])
		else $error("fault output not released under reset");
	a_hold_after_release: assert property ($rose(reset_out_n) |-> rel_cnt >= HOLD_US * 100 - 100)
		else $error("reset output released before hold delay");
	a_fault_pulse_max: assert property (low_cnt <= HOLD_US * 100 + 200)
		else $error("fault output pulse longer than hold delay");
	a_kick_restarts: assert property ($fell(watchdog_fault_out_n) |-> kick_age >= BASE_US * 100 - 200)
		else $error("fault raised too soon after a kick");
	a_disabled_quiet: assert property (!watchdog_run_enable [*8] |-> watchdog_fault_out_n)
		else $error("fault output low while watchdog disabled");
	a_bus_always_okay: assert property (hreadyout && !hresp)
		else $error("bus slave not ready or not okay");
endmodule

bind timeout_watchdog_supervisor wd_asserts #(.BASE_US(BASE_TIMEOUT_US), .HOLD_US(HOLD_DELAY_US))
	i_wd_asserts (.clk(clk), .reset(reset), .manual_reset_n(manual_reset_n),
	.supply_low(supply_low), .watchdog_kick_in(watchdog_kick_in),
	.watchdog_run_enable(watchdog_run_enable), .hreadyout(hreadyout), .hresp(hresp),
	.reset_out_n(reset_out_n), .watchdog_fault_out_n(watchdog_fault_out_n));

// ==== verilog/pin_sync.sv ====
/*
 * Two-flop synchroniser for the six asynchronous pin inputs.
 * Assumes the pins change freely relative to clk.
 */
`include "watchdog_defines.svh"

module pin_sync (
	input wire logic clk,
	input wire logic reset,
	input wire logic [5:0] pins,
	output logic [5:0] synced
);
	watchdog_pkg::sync_state_t s;
	watchdog_pkg::sync_state_t n;

	// first stage feeds only the second stage
	always_comb begin
		n.meta = pins;
		n.sync = s.meta;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s.meta <= `SYNC_RESET_VAL;
			s.sync <= `SYNC_RESET_VAL;
		end else begin
			s <= n;
		end
	end

	assign synced = s.sync;
endmodule

// ==== verilog/stable_filter.sv ====
/*
 * Adopts a new two-bit setting only after it has stood unchanged for
 * HOLD_CYCLES clocks. Assumes its input is already synchronised.
 */
module stable_filter #(
	parameter logic [15:0] HOLD_CYCLES = 16'h0001
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [1:0] din,
	output logic [1:0] dout
);
	watchdog_pkg::filt_state_t s;
	watchdog_pkg::filt_state_t n;

	always_comb begin
		n = s;
		if (din != s.cand) begin
			n.cand = din;
			n.cnt = '0;
		end else if (s.cnt >= HOLD_CYCLES - 16'h0001) begin
			n.held = s.cand;
		end else begin
			n.cnt = s.cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign dout = s.held;
endmodule

// ==== verilog/timeout_watchdog_supervisor.sv ====
/*
 * Timeout watchdog with manual-reset and undervoltage supervision, plus an
 * AHB-Lite register slave for output options and status.
 * Assumes one AHB-Lite master and that this slave's hreadyout is the bus hready.
 * Time is kept in microsecond ticks made from clk.
 */
`include "watchdog_defines.svh"

module timeout_watchdog_supervisor #(
	parameter int unsigned BASE_TIMEOUT_US = `BASE_TIMEOUT_DEFAULT_US,
	parameter int unsigned START_DELAY_US = `START_DELAY_DEFAULT_US,
	parameter int unsigned HOLD_DELAY_US = `HOLD_DELAY_DEFAULT_US,
	parameter logic [8:0] SCALE_FACTOR_0 = `SCALE_FACTOR_0,
	parameter logic [8:0] SCALE_FACTOR_1 = `SCALE_FACTOR_1,
	parameter logic [8:0] SCALE_FACTOR_2 = `SCALE_FACTOR_2,
	parameter logic [8:0] SCALE_FACTOR_3 = `SCALE_FACTOR_3,
	parameter int unsigned SET_HOLD_CYCLES = `SET_HOLD_CYCLES,
	parameter int unsigned ENABLE_HOLD_CYCLES = `ENABLE_HOLD_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic manual_reset_n,
	input wire logic supply_low,
	input wire logic watchdog_kick_in,
	input wire logic watchdog_run_enable,
	input wire logic scale_select_0,
	input wire logic scale_select_1,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic reset_out_n,
	output logic watchdog_fault_out_n
);
	// out-of-range build values are pulled into the legal span
	localparam int unsigned BASE_US = (BASE_TIMEOUT_US < `BASE_TIMEOUT_MIN_US) ?
		`BASE_TIMEOUT_MIN_US : ((BASE_TIMEOUT_US > `BASE_TIMEOUT_MAX_US) ?
		`BASE_TIMEOUT_MAX_US : BASE_TIMEOUT_US);
	localparam int unsigned HOLD_US = (HOLD_DELAY_US < `HOLD_DELAY_MIN_US) ?
		`HOLD_DELAY_MIN_US : ((HOLD_DELAY_US > `HOLD_DELAY_MAX_US) ?
		`HOLD_DELAY_MAX_US : HOLD_DELAY_US);
	localparam int unsigned START_US = (START_DELAY_US > `START_DELAY_MAX_US) ?
		`START_DELAY_MAX_US : START_DELAY_US;
	localparam int unsigned KICK_QUAL = (`KICK_QUAL_CYCLES < 1) ? 1 : `KICK_QUAL_CYCLES;

	watchdog_pkg::core_state_t s;
	watchdog_pkg::core_state_t next_s;

	logic [5:0] pins_sync;
	logic kick_s;
	logic manual_n_s;
	logic supply_low_s;
	logic [1:0] enable_f;
	logic [1:0] scale_f;

	logic tick;
	logic kick_q;
	logic sup_cond;
	logic reset_active;
	logic wd_trip;
	logic soft_clear;
	logic bus_wr;
	logic bus_acc;
	logic [8:0] factor;
	logic [35:0] limit;
	logic [31:0] rd_word;

	pin_sync u_sync (
		.clk(clk),
		.reset(reset),
		.pins({scale_select_1, scale_select_0, watchdog_run_enable, supply_low,
			manual_reset_n, watchdog_kick_in}),
		.synced(pins_sync)
	);

	assign kick_s = pins_sync[0];
	assign manual_n_s = pins_sync[1];
	assign supply_low_s = pins_sync[2];

	// a setting counts only once the host has held it for the documented time
	stable_filter #(
		.HOLD_CYCLES(16'(SET_HOLD_CYCLES))
	) u_scale_filter (
		.clk(clk),
		.reset(reset),
		.din(pins_sync[5:4]),
		.dout(scale_f)
	);

	stable_filter #(
		.HOLD_CYCLES(16'(ENABLE_HOLD_CYCLES))
	) u_enable_filter (
		.clk(clk),
		.reset(reset),
		.din({1'b0, pins_sync[3]}),
		.dout(enable_f)
	);

	always_comb begin
		next_s = s;
		tick = (s.tick_cnt == 7'(`TICK_CYCLES - 1));
		kick_q = 1'b0;
		wd_trip = 1'b0;
		sup_cond = ~manual_n_s | supply_low_s;
		reset_active = (s.rs != watchdog_pkg::RST_IDLE);
		bus_acc = hsel & hready & htrans[1] & (hsize == `HSIZE_WORD);
		bus_wr = s.ap_valid & s.ap_write;
		soft_clear = bus_wr & (s.ap_addr == `REG_CLEAR) & hwdata[`CLEAR_BIT];
		rd_word = '0;

		// scaling follows the filtered select pins at every cycle
		case (scale_f)
			2'h0: factor = SCALE_FACTOR_0;
			2'h1: factor = SCALE_FACTOR_1;
			2'h2: factor = SCALE_FACTOR_2;
			default: factor = SCALE_FACTOR_3;
		endcase
		limit = 36'(BASE_US) * 36'(factor);

		next_s.tick_cnt = tick ? '0 : s.tick_cnt + 7'h01;

		// a falling edge counts once the line has stayed low for KICK_QUAL
		// cycles, which rejects glitches yet accepts any legal host pulse
		if (kick_s) begin
			next_s.kick_armed = 1'b1;
			next_s.kick_low = '0;
		end else if (s.kick_armed) begin
			if (s.kick_low == 6'(KICK_QUAL - 1)) begin
				kick_q = 1'b1;
				next_s.kick_armed = 1'b0;
				next_s.kick_low = '0;
			end else begin
				next_s.kick_low = s.kick_low + 6'h01;
			end
		end

		case (s.wd)
			watchdog_pkg::WD_OFF: begin
				next_s.wd_cnt = '0;
				if (enable_f[0] && !reset_active) begin
					next_s.wd = watchdog_pkg::WD_START;
				end
			end
			watchdog_pkg::WD_START: begin
				if (!enable_f[0]) begin
					next_s.wd = watchdog_pkg::WD_OFF;
				end else if (s.wd_cnt >= 36'(START_US)) begin
					next_s.wd = watchdog_pkg::WD_RUN;
					next_s.wd_cnt = '0;
				end else if (tick) begin
					next_s.wd_cnt = s.wd_cnt + 36'h0_0000_0001;
				end
			end
			watchdog_pkg::WD_RUN: begin
				if (!enable_f[0]) begin
					next_s.wd = watchdog_pkg::WD_OFF;
				end else if (kick_q) begin
					next_s.wd_cnt = '0;
				end else if (s.wd_cnt >= limit) begin
					wd_trip = 1'b1;
					next_s.wd_cnt = '0;
					next_s.wd = s.ctrl_separate ? watchdog_pkg::WD_FAULT :
						watchdog_pkg::WD_OFF;
				end else if (tick) begin
					next_s.wd_cnt = s.wd_cnt + 36'h0_0000_0001;
				end
			end
			watchdog_pkg::WD_FAULT: begin
				if (!enable_f[0]) begin
					next_s.wd = watchdog_pkg::WD_OFF;
				end else if (s.ctrl_latched) begin
					if (soft_clear) begin
						next_s.wd = watchdog_pkg::WD_RUN;
					end
				end else if (s.wd_cnt >= 36'(HOLD_US)) begin
					next_s.wd = watchdog_pkg::WD_RUN;
					next_s.wd_cnt = '0;
				end else if (tick) begin
					next_s.wd_cnt = s.wd_cnt + 36'h0_0000_0001;
				end
			end
			default: begin
				next_s.wd = watchdog_pkg::WD_OFF;
				next_s.wd_cnt = '0;
			end
		endcase

		// reset output wins: watchdog timing stops and restarts afterwards
		if (reset_active) begin
			next_s.wd = watchdog_pkg::WD_OFF;
			next_s.wd_cnt = '0;
		end

		// latched trip on the reset pin; a new trip beats a same-cycle clear
		next_s.rst_latch = (s.rst_latch & ~soft_clear & enable_f[0]) |
			(wd_trip & ~s.ctrl_separate & s.ctrl_latched);

		case (s.rs)
			watchdog_pkg::RST_ACTIVE: begin
				next_s.hold_cnt = '0;
				if (!sup_cond && !s.rst_latch) begin
					next_s.rs = watchdog_pkg::RST_HOLD;
				end
			end
			watchdog_pkg::RST_HOLD: begin
				if (sup_cond || s.rst_latch) begin
					next_s.rs = watchdog_pkg::RST_ACTIVE;
				end else if (s.hold_cnt >= 24'(HOLD_US)) begin
					next_s.rs = watchdog_pkg::RST_IDLE;
				end else if (tick) begin
					next_s.hold_cnt = s.hold_cnt + 24'h00_0001;
				end
			end
			watchdog_pkg::RST_IDLE: begin
				next_s.hold_cnt = '0;
				if (sup_cond) begin
					next_s.rs = watchdog_pkg::RST_ACTIVE;
				end else if (wd_trip && !s.ctrl_separate) begin
					// a timed trip goes straight to the hold phase, or to RST_ACTIVE when ctrl_latched is set
					next_s.rs = s.ctrl_latched ? watchdog_pkg::RST_ACTIVE :
						watchdog_pkg::RST_HOLD;
				end
			end
			default: begin
				next_s.rs = watchdog_pkg::RST_ACTIVE;
				next_s.hold_cnt = '0;
			end
		endcase

		next_s.reset_out_n = (next_s.rs == watchdog_pkg::RST_IDLE);
		next_s.fault_out_n = ~((next_s.wd == watchdog_pkg::WD_FAULT) &
			(next_s.rs == watchdog_pkg::RST_IDLE));

		// register writes land in the data phase
		if (bus_wr && s.ap_addr == `REG_CTRL) begin
			next_s.ctrl_latched = hwdata[`CTRL_LATCHED_BIT];
			next_s.ctrl_separate = hwdata[`CTRL_SEPARATE_BIT];
		end

		case (haddr[7:0])
			`REG_CTRL: begin
				rd_word[`CTRL_LATCHED_BIT] = s.ctrl_latched;
				rd_word[`CTRL_SEPARATE_BIT] = s.ctrl_separate;
			end
			`REG_STATUS: begin
				rd_word[`STAT_RESET_BIT] = ~s.reset_out_n;
				rd_word[`STAT_FAULT_BIT] = ~s.fault_out_n;
				rd_word[`STAT_SUPPLY_LOW_BIT] = supply_low_s;
				rd_word[`STAT_MANUAL_BIT] = ~manual_n_s;
				rd_word[`STAT_ENABLE_BIT] = enable_f[0];
				rd_word[`STAT_SCALE_LSB +: 2] = scale_f;
				rd_word[`STAT_WD_STATE_LSB +: 4] = s.wd;
				rd_word[`STAT_RST_STATE_LSB +: 3] = s.rs;
			end
			`REG_COUNT: begin
				rd_word = s.wd_cnt[31:0];
			end
			default: begin
				rd_word = '0;
			end
		endcase

		// zero-wait slave: data for a read is ready in its data phase
		next_s.ap_valid = bus_acc;
		next_s.ap_write = hwrite;
		next_s.ap_addr = haddr[7:0];
		next_s.hrdata = (bus_acc && !hwrite) ? rd_word : '0;
		next_s.hreadyout = 1'b1;
		next_s.hresp = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s.tick_cnt <= '0;
			s.kick_armed <= 1'b0;
			s.kick_low <= '0;
			s.wd_cnt <= '0;
			s.wd <= watchdog_pkg::WD_OFF;
			s.rs <= watchdog_pkg::RST_ACTIVE;
			s.hold_cnt <= '0;
			s.rst_latch <= 1'b0;
			s.ctrl_latched <= `CTRL_LATCHED_RESET;
			s.ctrl_separate <= `CTRL_SEPARATE_RESET;
			s.ap_valid <= 1'b0;
			s.ap_write <= 1'b0;
			s.ap_addr <= '0;
			s.hrdata <= '0;
			s.hreadyout <= 1'b1;
			s.hresp <= 1'b0;
			s.reset_out_n <= 1'b0;
			s.fault_out_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign hreadyout = s.hreadyout;
	assign hresp = s.hresp;
	assign hrdata = s.hrdata;
	assign reset_out_n = s.reset_out_n;
	assign watchdog_fault_out_n = s.fault_out_n;
endmodule

// ==== verilog/watchdog_defines.svh ====
/*
 * Constants of the timeout watchdog supervisor: timing figures, derived
 * cycle counts, parameter defaults and ranges, register offsets and fields.
 * Assumes a 100 MHz clock and AHB-Lite word access to the registers.
 */
`ifndef WATCHDOG_DEFINES_SVH
`define WATCHDOG_DEFINES_SVH

`define CLK_PERIOD_NS 10
`define NS_PER_US 1000
`define TICK_CYCLES (`NS_PER_US / `CLK_PERIOD_NS)

`define KICK_MIN_NS 500
`define KICK_QUAL_NS 200
`define KICK_QUAL_CYCLES (`KICK_QUAL_NS / `CLK_PERIOD_NS)

`define SET_HOLD_US 150
`define SET_HOLD_CYCLES ((`SET_HOLD_US * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ENABLE_HOLD_US 200
`define ENABLE_HOLD_CYCLES ((`ENABLE_HOLD_US * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define BASE_TIMEOUT_MIN_US 1000
`define BASE_TIMEOUT_MAX_US 100000000
`define HOLD_DELAY_MIN_US 2000
`define HOLD_DELAY_MAX_US 10000000
`define START_DELAY_MAX_US 10000000

`define BASE_TIMEOUT_DEFAULT_US 10000
`define START_DELAY_DEFAULT_US 0
`define HOLD_DELAY_DEFAULT_US 2000
`define SCALE_FACTOR_0 9'h001
`define SCALE_FACTOR_1 9'h008
`define SCALE_FACTOR_2 9'h040
`define SCALE_FACTOR_3 9'h100

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_CLEAR 8'h08
`define REG_COUNT 8'h0C
`define CTRL_LATCHED_BIT 0
`define CTRL_SEPARATE_BIT 1
`define CTRL_LATCHED_RESET 1'b0
`define CTRL_SEPARATE_RESET 1'b1
`define CLEAR_BIT 0
`define STAT_RESET_BIT 0
`define STAT_FAULT_BIT 1
`define STAT_SUPPLY_LOW_BIT 2
`define STAT_MANUAL_BIT 3
`define STAT_ENABLE_BIT 4
`define STAT_SCALE_LSB 5
`define STAT_WD_STATE_LSB 8
`define STAT_RST_STATE_LSB 12
`define HSIZE_WORD 3'h2

// pin order in the synchroniser: scale[1:0], enable, supply_low, manual_n, kick
`define SYNC_RESET_VAL 6'h03

`endif

// ==== verilog/watchdog_pkg.sv ====
/*
 * Types of the timeout watchdog supervisor: state encodings and the packed
 * state records of each module. Constants live in watchdog_defines.svh.
 */
package watchdog_pkg;

	typedef enum logic [3:0] {
		WD_OFF = 4'h1,
		WD_START = 4'h2,
		WD_RUN = 4'h4,
		WD_FAULT = 4'h8
	} wd_state_t;

	typedef enum logic [2:0] {
		RST_ACTIVE = 3'h1,
		RST_HOLD = 3'h2,
		RST_IDLE = 3'h4
	} rst_state_t;

	typedef struct packed {
		logic [5:0] meta;
		logic [5:0] sync;
	} sync_state_t;

	typedef struct packed {
		logic [1:0] held;
		logic [1:0] cand;
		logic [15:0] cnt;
	} filt_state_t;

	typedef struct packed {
		logic [6:0] tick_cnt;
		logic kick_armed;
		logic [5:0] kick_low;
		logic [35:0] wd_cnt;
		wd_state_t wd;
		rst_state_t rs;
		logic [23:0] hold_cnt;
		logic rst_latch;
		logic ctrl_latched;
		logic ctrl_separate;
		logic ap_valid;
		logic ap_write;
		logic [7:0] ap_addr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
		logic reset_out_n;
		logic fault_out_n;
	} core_state_t;

endpackage
